// [design/rsw_pkg.sv]
// constants and types for the timer status, interrupt, wake and alarm registers
// How it works
// RULE_01 - settled flag sets when switching flag falls
// RULE_02 - switching flag high from clock enable write
// RULE_03 - sync ready sets when sync busy falls
// RULE_04 - synchronized register writes discarded while busy
// RULE_05 - interval flag sets on selected tap rise
// RULE_06 - compare hit sets on counter match
// RULE_07 - wraparound flag sets on counter overflow
// RULE_08 - status clear ones clear flag and request
// RULE_09 - enable set ones set mask bits
// RULE_10 - enable clear ones clear mask bits
// RULE_11 - mask state reads enabled sources
// RULE_12 - busy hides wake, compare, interval registers
// RULE_13 - interval wake on enabled tap rise
// RULE_14 - compare wake on enabled counter match
// RULE_15 - overflow wake when enabled
// RULE_16 - two full 32-bit compare values
// RULE_17 - interval select 0 picks tap for flag 0
// RULE_18 - interval select 1 picks tap for flag 1
// RULE_19 - busy held through the domain crossing
// RULE_20 - shutdown wakeup clears the mask only
// RULE_21 - irq while any flag and mask set
// RULE_22 - wake request independent of interrupt mask
package rsw_pkg;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_CLEAR = 8'h0C;
    localparam logic [7:0] OFS_IER = 8'h10;
    localparam logic [7:0] OFS_IDR = 8'h14;
    localparam logic [7:0] OFS_IMR = 8'h18;
    localparam logic [7:0] OFS_WAKE = 8'h1C;
    localparam logic [7:0] OFS_CMP0 = 8'h20;
    localparam logic [7:0] OFS_CMP1 = 8'h24;
    localparam logic [7:0] OFS_INT0 = 8'h30;
    localparam logic [7:0] OFS_INT1 = 8'h34;
    localparam logic [7:0] OFS_CLKCTL = 8'h40;
    localparam int BIT_OVF = 0;
    localparam int BIT_CMP0 = 8;
    localparam int BIT_CMP1 = 9;
    localparam int BIT_PER0 = 16;
    localparam int BIT_PER1 = 17;
    localparam int BIT_BUSY = 24;
    localparam int BIT_READY = 25;
    localparam int BIT_SWITCHING = 28;
    localparam int BIT_SETTLED = 29;
    localparam logic [31:0] FLAG_MASK = 32'h2203_0301;
    localparam logic [31:0] WAKE_MASK = 32'h0003_0301;
    localparam int TAP_W = 5;
    localparam logic [3:0] SYNC_CYCLES = 4'h4;
    localparam logic [3:0] CLK_CYCLES = 4'h8;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    typedef struct packed {
        logic [31:0] flags;
        logic [31:0] mask;
        logic [31:0] wake;
        logic [31:0] cmp0;
        logic [31:0] cmp1;
        logic [TAP_W-1:0] tap0;
        logic [TAP_W-1:0] tap1;
        logic [3:0] sync_cnt;
        logic [3:0] clk_cnt;
        logic busy_q;
        logic switching_q;
        logic [1:0] tap_q;
        logic aw_ok;
        logic w_ok;
        logic [7:0] awaddr;
        logic [31:0] wdata;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic irq;
        logic wake_req;
    } rsw_state_t;
endpackage

// [design/rsw_regs.sv]
// status, interrupt mask, wake enable, compare and interval registers on AXI4-Lite
//
// Implementation choice: the AXI4-Lite register port.
`timescale 1ns/10ps
module rsw_regs (
    input wire logic clk,
    input wire logic srst,
    input wire logic shutdown_wake,
    input wire logic [31:0] counter_value,
    input wire logic counter_wrap,
    input wire logic [31:0] prescaler_taps,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic irq,
    output logic wake_req,
    output logic sync_busy,
    output logic source_switching_flag
);
    import rsw_pkg::*;

    rsw_state_t st;
    rsw_state_t next_st;
    logic [31:0] events;
    logic [1:0] tap_now;
    logic do_write;
    logic sync_write;
    logic [31:0] rd_word;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = data[i*8 +: 8];
            end
        end
        return r;
    endfunction

    function automatic logic synced(input logic [7:0] a);
        return a == OFS_CLEAR || a == OFS_WAKE || a == OFS_CMP0 || a == OFS_CMP1 || a == OFS_INT0 || a == OFS_INT1;
    endfunction

    // ready outputs are decoded from the registered handshake flags; only arready is a registered flag itself
    assign s_axi_awready = !st.aw_ok && !st.bvalid;
    assign s_axi_wready = !st.w_ok && !st.bvalid;
    assign s_axi_bvalid = st.bvalid;
    assign s_axi_bresp = st.bresp;
    assign s_axi_arready = st.arready;
    assign s_axi_rvalid = st.rvalid;
    assign s_axi_rdata = st.rdata;
    assign s_axi_rresp = st.rresp;
    assign irq = st.irq;
    assign wake_req = st.wake_req;
    assign sync_busy = st.busy_q;
    assign source_switching_flag = st.switching_q;

    assign tap_now = {prescaler_taps[st.tap1], prescaler_taps[st.tap0]}; // RULE_17 RULE_18

    always_comb begin
        events = '0;
        events[BIT_OVF] = counter_wrap; // RULE_07
        events[BIT_CMP0] = counter_value == st.cmp0; // RULE_06 RULE_16
        events[BIT_CMP1] = counter_value == st.cmp1; // RULE_06 RULE_16
        events[BIT_PER0] = tap_now[0] && !st.tap_q[0]; // RULE_05
        events[BIT_PER1] = tap_now[1] && !st.tap_q[1]; // RULE_05
        events[BIT_READY] = st.busy_q && st.sync_cnt == 4'h1; // RULE_03
        events[BIT_SETTLED] = st.switching_q && st.clk_cnt == 4'h1; // RULE_01
    end

    always_comb begin
        rd_word = '0;
        unique case (s_axi_araddr)
            OFS_STATUS: rd_word = (st.flags & FLAG_MASK) | ({31'h0, st.busy_q} << BIT_BUSY)
                | ({31'h0, st.switching_q} << BIT_SWITCHING); // RULE_02
            OFS_IMR: rd_word = st.mask & FLAG_MASK; // RULE_11
            OFS_WAKE: rd_word = st.busy_q ? 32'h0 : st.wake; // RULE_12
            OFS_CMP0: rd_word = st.busy_q ? 32'h0 : st.cmp0; // RULE_12
            OFS_CMP1: rd_word = st.busy_q ? 32'h0 : st.cmp1; // RULE_12
            OFS_INT0: rd_word = st.busy_q ? 32'h0 : {27'h0, st.tap0}; // RULE_12
            OFS_INT1: rd_word = st.busy_q ? 32'h0 : {27'h0, st.tap1}; // RULE_12
            default: rd_word = '0;
        endcase
    end

    always_comb begin
        next_st = st;
        do_write = st.aw_ok && st.w_ok && !st.bvalid;
        sync_write = do_write && synced(st.awaddr);
        next_st.tap_q = tap_now;
        // set wins over a same-cycle clear
        next_st.flags = st.flags;
        if (s_axi_awvalid && s_axi_awready) begin
            next_st.aw_ok = 1'b1;
            next_st.awaddr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_st.w_ok = 1'b1;
            next_st.wdata = merge(32'h0, s_axi_wdata, s_axi_wstrb);
        end
        if (st.busy_q) begin
            next_st.sync_cnt = st.sync_cnt - 4'h1;
            next_st.busy_q = st.sync_cnt != 4'h1; // RULE_19
        end
        if (st.switching_q) begin
            next_st.clk_cnt = st.clk_cnt - 4'h1;
            next_st.switching_q = st.clk_cnt != 4'h1;
        end
        if (do_write) begin
            next_st.aw_ok = 1'b0;
            next_st.w_ok = 1'b0;
            next_st.bvalid = 1'b1;
            next_st.bresp = RESP_OKAY;
            if (synced(st.awaddr) && st.busy_q) begin
                next_st.bresp = RESP_OKAY; // RULE_04 RULE_12
            end else begin
                unique case (st.awaddr)
                    OFS_CLEAR: next_st.flags = st.flags & ~(st.wdata & FLAG_MASK); // RULE_08
                    OFS_IER: next_st.mask = st.mask | (st.wdata & FLAG_MASK); // RULE_09
                    OFS_IDR: next_st.mask = st.mask & ~(st.wdata & FLAG_MASK); // RULE_10
                    OFS_WAKE: next_st.wake = st.wdata & WAKE_MASK;
                    OFS_CMP0: next_st.cmp0 = st.wdata;
                    OFS_CMP1: next_st.cmp1 = st.wdata;
                    OFS_INT0: next_st.tap0 = st.wdata[TAP_W-1:0];
                    OFS_INT1: next_st.tap1 = st.wdata[TAP_W-1:0];
                    OFS_CLKCTL: begin
                        next_st.switching_q = 1'b1; // RULE_02
                        next_st.clk_cnt = CLK_CYCLES;
                    end
                    OFS_STATUS, OFS_IMR: next_st.bresp = RESP_OKAY;
                    default: next_st.bresp = RESP_SLVERR;
                endcase
                if (sync_write) begin
                    next_st.busy_q = 1'b1; // RULE_19
                    next_st.sync_cnt = SYNC_CYCLES;
                end
            end
        end
        next_st.flags = next_st.flags | (events & FLAG_MASK); // RULE_01 RULE_03 RULE_05 RULE_06 RULE_07
        if (st.bvalid && s_axi_bready) begin
            next_st.bvalid = 1'b0;
        end
        next_st.arready = 1'b0;
        if (s_axi_arvalid && !st.arready && !st.rvalid) begin
            next_st.arready = 1'b1;
            next_st.rvalid = 1'b1;
            next_st.rdata = rd_word;
            next_st.rresp = RESP_OKAY;
        end
        if (st.rvalid && s_axi_rready) begin
            next_st.rvalid = 1'b0;
        end
        if (shutdown_wake) begin
            next_st.mask = '0; // RULE_20
        end
        next_st.irq = |(next_st.flags & next_st.mask & FLAG_MASK); // RULE_21
        next_st.wake_req = |(events & st.wake & WAKE_MASK); // RULE_13 RULE_14 RULE_15 RULE_22
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // irq is registered from the same next-state copy as flags and mask, so it matches them every cycle
    irq_follows_a: assert property (@(posedge clk) disable iff (srst)
        irq == |(st.flags & st.mask & FLAG_MASK)) else $error("irq not tied to flags and mask"); // RULE_21
    busy_hold_a: assert property (@(posedge clk) disable iff (srst)
        $rose(sync_busy) |-> sync_busy [*4] ##1 !sync_busy) else $error("busy length wrong"); // RULE_19
    ready_on_fall_a: assert property (@(posedge clk) disable iff (srst)
        $fell(sync_busy) |-> st.flags[BIT_READY]) else $error("sync ready not set"); // RULE_03
    settled_on_fall_a: assert property (@(posedge clk) disable iff (srst)
        $fell(source_switching_flag) |-> st.flags[BIT_SETTLED]) else $error("settled not set"); // RULE_01
    wrap_sets_a: assert property (@(posedge clk) disable iff (srst)
        counter_wrap |=> st.flags[BIT_OVF]) else $error("wraparound lost"); // RULE_07
    cmp_sets_a: assert property (@(posedge clk) disable iff (srst)
        counter_value == st.cmp0 |=> st.flags[BIT_CMP0]) else $error("compare hit lost"); // RULE_06
    busy_discard_a: assert property (@(posedge clk) disable iff (srst)
        do_write && st.busy_q && st.awaddr == OFS_CMP0 |=> $stable(st.cmp0)) else $error("write while busy"); // RULE_04
    ier_sets_a: assert property (@(posedge clk) disable iff (srst)
        do_write && st.awaddr == OFS_IER && !shutdown_wake |=> (st.mask & $past(st.wdata) & FLAG_MASK)
        == ($past(st.wdata) & FLAG_MASK)) else $error("mask not set"); // RULE_09
    idr_clears_a: assert property (@(posedge clk) disable iff (srst)
        do_write && st.awaddr == OFS_IDR |=> (st.mask & $past(st.wdata)) == 32'h0) else $error("mask not cleared"); // RULE_10
    wake_gate_a: assert property (@(posedge clk) disable iff (srst)
        counter_wrap && !st.wake[BIT_OVF] && !(|(events & st.wake)) |=> !wake_req) else $error("wake ungated"); // RULE_15
    shut_mask_a: assert property (@(posedge clk) disable iff (srst)
        shutdown_wake |=> st.mask == 32'h0) else $error("mask kept on wakeup"); // RULE_20
endmodule

// [testbench/tb_top.sv]
// self-checking bench for the timer status, interrupt, wake and compare registers
`timescale 1ns/10ps
module tb_top;
    import rsw_pkg::*;
    logic clk = 1'b0;
    logic srst = 1'b1;
    logic shutdown_wake = 1'b0;
    logic counter_wrap = 1'b0;
    logic [31:0] counter_value = 32'h1234_5678;
    logic [31:0] prescaler_taps = 32'h0;
    logic [7:0] awaddr = 8'h00;
    logic [7:0] araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic awvalid = 1'b0;
    logic wvalid = 1'b0;
    logic bready = 1'b0;
    logic arvalid = 1'b0;
    logic rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, irq, wake_req, sync_busy, switching;
    logic [1:0] bresp;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic [31:0] st;
    logic [31:0] w0;
    logic [31:0] wake_cnt = 32'h0;
    int error_cnt = 0;
    int comparisons = 0;
    int n;
    rsw_regs rsw_regs_inst (.clk(clk), .srst(srst), .shutdown_wake(shutdown_wake),
        .counter_value(counter_value), .counter_wrap(counter_wrap), .prescaler_taps(prescaler_taps),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
        .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .irq(irq), .wake_req(wake_req), .sync_busy(sync_busy),
        .source_switching_flag(switching));
    always #5 clk = ~clk;
    // wake is a one-cycle pulse, so count it here rather than poll for it
    always @(posedge clk) if (wake_req === 1'b1) wake_cnt <= wake_cnt + 32'h1;
    task automatic final_report();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("mismatch t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic tmo(input int k);
        if (k >= 40) begin
            error_cnt++;
            $display("mismatch t=%0t wait ran out", $time);
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (awready === 1'b1) awvalid <= 1'b0;
            if (wready === 1'b1) wvalid <= 1'b0;
            if (bvalid === 1'b1) break;
        end
        bready <= 1'b0;
        tmo(n);
        chk(32'(bresp), 32'(er));
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (arready === 1'b1) arvalid <= 1'b0;
            if (rvalid === 1'b1) break;
        end
        st = rdata;
        rready <= 1'b0;
        tmo(n);
        chk(32'(rresp), 32'(RESP_OKAY));
        chk(st, e);
    endtask
    // synchronized writes must wait out the busy window or they are dropped
    task automatic idle();
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (sync_busy === 1'b0) break;
        end
        tmo(n);
    endtask
    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask
    task automatic t_reset();
        rdc(OFS_STATUS, 32'h0);
        rdc(OFS_IMR, 32'h0);
        rdc(OFS_WAKE, 32'h0);
        rdc(OFS_CMP0, 32'h0);
        rdc(OFS_INT1, 32'h0);
    endtask
    task automatic t_mask();
        wr(OFS_IER, 32'hFFFF_FFFF, RESP_OKAY);
        rdc(OFS_IMR, FLAG_MASK);
        wr(OFS_IDR, 32'h0000_0300, RESP_OKAY);
        wr(OFS_IER, 32'h0, RESP_OKAY);
        rdc(OFS_IMR, 32'h2203_0001);
    endtask
    task automatic t_sync();
        wr(OFS_CMP0, 32'hA5A5_0002, RESP_OKAY);
        #1 chk(32'(sync_busy), 32'h1);
        wr(OFS_CMP1, 32'h5A5A_0003, RESP_OKAY);
        idle();
        rdc(OFS_CMP1, 32'h0);
        rdc(OFS_STATUS, 32'h0200_0000);
        wr(OFS_CLEAR, 32'h0200_0000, RESP_OKAY);
        rdc(OFS_CMP0, 32'h0);
        idle();
        rdc(OFS_CMP0, 32'hA5A5_0002);
        wr(OFS_CLEAR, 32'h0200_0000, RESP_OKAY);
        rdc(OFS_STATUS, 32'h0100_0000);
        idle();
    endtask
    task automatic t_events();
        wr(OFS_WAKE, 32'h0000_0101, RESP_OKAY);
        idle();
        w0 = wake_cnt;
        @(posedge clk) counter_value <= 32'hA5A5_0002;
        @(posedge clk) counter_value <= 32'h0;
        @(posedge clk) counter_value <= 32'h1234_5678;
        counter_wrap <= 1'b1;
        @(posedge clk) counter_wrap <= 1'b0;
        settle();
        chk(wake_cnt, w0 + 32'h2);
        rdc(OFS_STATUS, 32'h0200_0301);
        wr(OFS_IDR, 32'hFFFF_FFFF, RESP_OKAY);
        settle();
        chk(32'(irq), 32'h0);
        wr(OFS_IER, 32'h0000_0100, RESP_OKAY);
        settle();
        chk(32'(irq), 32'h1);
        wr(OFS_CLEAR, 32'h0000_0301, RESP_OKAY);
        idle();
        settle();
        chk(32'(irq), 32'h0);
        rdc(OFS_STATUS, 32'h0200_0000);
    endtask
    task automatic t_taps();
        wr(OFS_INT0, 32'h3, RESP_OKAY);
        idle();
        wr(OFS_INT1, 32'h5, RESP_OKAY);
        idle();
        wr(OFS_WAKE, WAKE_MASK & 32'hFFFF_0000, RESP_OKAY);
        idle();
        rdc(OFS_INT0, 32'h3);
        w0 = wake_cnt;
        @(posedge clk) prescaler_taps <= 32'h10;
        @(posedge clk) prescaler_taps <= 32'h18;
        @(posedge clk) prescaler_taps <= 32'h38;
        counter_wrap <= 1'b1;
        @(posedge clk) counter_wrap <= 1'b0;
        settle();
        rdc(OFS_STATUS, 32'h0203_0001);
        chk(wake_cnt, w0 + 32'h2);
        @(posedge clk) shutdown_wake <= 1'b1;
        @(posedge clk) shutdown_wake <= 1'b0;
        rdc(OFS_IMR, 32'h0);
        rdc(OFS_WAKE, 32'h0003_0000);
    endtask
    task automatic t_clock();
        wr(OFS_CLKCTL, 32'h1, RESP_OKAY);
        #1 chk(32'(switching), 32'h1);
        for (n = 0; n < 40; n++) begin
            @(posedge clk);
            if (switching === 1'b0) break;
        end
        tmo(n);
        settle();
        rdc(OFS_STATUS, 32'h2203_0001);
        wr(8'h60, 32'h1, RESP_SLVERR);
        rdc(8'h60, 32'h0);
    endtask
    initial begin
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        t_reset();
        t_mask();
        t_sync();
        t_events();
        t_taps();
        t_clock();
        final_report();
    end
endmodule
